/* design/asr_defines.svh */
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH
// Memory organisation.
`define ASR_ADDR_W          18
`define ASR_DATA_W          16
// Timing figures in picoseconds, slower grade as the default.
`define ASR_CLK_PS          25000
`define ASR_READ_CYCLE_PS   12000
`define ASR_ADDR_DATA_PS    12000
`define ASR_WRITE_CYCLE_PS  12000
`define ASR_WRITE_END_PS    8000
`define ASR_DATA_SETUP_PS   6000
`define ASR_FLOAT_PS        6000
// Least times round up to whole cycles, never below one.
`define ASR_CYC_UP(ps) (((ps) + `ASR_CLK_PS - 1) / `ASR_CLK_PS)
`define ASR_MIN1(n) (((n) < 1) ? 1 : (n))
`define ASR_READ_CYC  `ASR_MIN1(`ASR_CYC_UP(`ASR_ADDR_DATA_PS) + 1)
`define ASR_WRITE_CYC `ASR_MIN1(`ASR_CYC_UP(`ASR_WRITE_END_PS))
`define ASR_TURN_CYC  `ASR_MIN1(`ASR_CYC_UP(`ASR_FLOAT_PS))
`endif

/* design/asr_pkg.sv */
package asr_pkg;
	typedef enum logic [2:0] {
		ASR_IDLE  = 3'b000,
		ASR_SETUP = 3'b001,
		ASR_READ  = 3'b010,
		ASR_WRITE = 3'b011,
		ASR_HOLD  = 3'b100,
		ASR_TURN  = 3'b101
	} asr_state_t;
endpackage : asr_pkg

/* design/asr_sync.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Two-stage synchroniser for the data pins.
// ----------------------------------------
module asr_sync #(
	parameter int WIDTH = 16
) (
	input  wire logic             mclk_in,
	input  wire logic             rst_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	// First stage feeds only the second stage.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : asr_sync

/* design/asr_ctrl.sv */
`timescale 1ns/1ps
`include "asr_defines.svh"
// Overview of operation
// RULE1: 256k words, 16 bits, two byte lanes.
// RULE2: Memory static; controller sets pin levels only.
// RULE3: Select high puts memory in standby.
// RULE4: Selected, strobes high: bus floats.
// RULE5: Read drives lanes whose select is low.
// RULE6: Write stores lanes whose select is low.
// RULE7: Write is overlap of select, strobe, lane.
// RULE8: Late select after strobe keeps outputs off.
// RULE9: Strobe high whenever address changes.
// RULE10: Never drive bus while memory drives.
// RULE11: Read cycle at least access time long.
// RULE12: Data valid soon after enable low.
// RULE13: Previous data held briefly after address.
// RULE14: Memory floats soon after deselect.
// RULE15: Memory drives no sooner than allowed.
// RULE16: Write pulse and cycle minimum widths.
// RULE17: Address settled before write begins.
// RULE18: Address held until write ends.
// RULE19: Data set up before write end, held.
// RULE20: Strobe low turns memory outputs off.
// RULE21: Memory output unknown until access elapses.
module asr_ctrl
	import asr_pkg::*;
#(
	parameter int AW = `ASR_ADDR_W,
	parameter int DW = `ASR_DATA_W
) (
	input  wire logic          mclk_in,
	input  wire logic          rst_in,
	input  wire logic          req_valid_in,
	output logic               req_ready_out,
	input  wire logic          req_write_in,
	input  wire logic [AW-1:0] req_addr_in,
	input  wire logic [DW-1:0] req_wdata_in,
	input  wire logic [1:0]    req_lane_en_in,
	output logic               rsp_valid_out,
	output logic      [DW-1:0] rsp_rdata_out,
	output logic      [AW-1:0] word_address_out,
	output logic               select_n_out,
	output logic               output_enable_n_out,
	output logic               write_strobe_n_out,
	output logic               low_lane_select_n_out,
	output logic               high_lane_select_n_out,
	input  wire logic [DW-1:0] shared_data_lines_in,
	output logic      [DW-1:0] shared_data_lines_out,
	output logic               shared_data_lines_oe_n_out
);
	localparam logic [3:0] READ_CYC  = 4'(`ASR_READ_CYC);
	localparam logic [3:0] WRITE_CYC = 4'(`ASR_WRITE_CYC);
	localparam logic [3:0] TURN_CYC  = 4'(`ASR_TURN_CYC);

	typedef struct packed {
		asr_state_t      state;
		logic [3:0]      cnt;
		logic            write;
		logic [AW-1:0]   addr;
		logic [DW-1:0]   wdata;
		logic [1:0]      lane_n;
		logic            sel_n;
		logic            oe_n;
		logic            we_n;
		logic            drive_n;
		logic            rsp_valid;
		logic [DW-1:0]   rdata;
	} asr_regs_t;

	asr_regs_t        r;
	asr_regs_t        next_r;
	logic [DW-1:0]    data_sync;

	// ----------------------------------------
	// Input synchronisation
	// ----------------------------------------
	// Read data passes two flops; it is sampled once the access time is met.
	asr_sync #(
		.WIDTH (DW)
	) u_sync (
		.mclk_in  (mclk_in),
		.rst_in   (rst_in),
		.async_in (shared_data_lines_in),
		.sync_out (data_sync)
	);

	// ----------------------------------------
	// Access sequencer
	// ----------------------------------------
	// Address is placed one cycle before any strobe goes low.
	always_comb begin
		next_r           = r;
		next_r.rsp_valid = 1'b0;
		unique case (r.state)
			ASR_IDLE: begin
				if (req_valid_in) begin
					next_r.addr   = req_addr_in; // RULE9
					next_r.write  = req_write_in;
					next_r.wdata  = req_wdata_in;
					next_r.lane_n = ~req_lane_en_in; // RULE5 RULE6
					next_r.state  = ASR_SETUP;
				end
			end
			ASR_SETUP: begin
				// Address is stable before the write window opens.
				next_r.sel_n  = 1'b0; // RULE17 RULE3
				next_r.cnt    = '0;
				if (r.write) begin
					next_r.we_n    = 1'b0; // RULE7 RULE20
					next_r.drive_n = 1'b0; // RULE19
					next_r.state   = ASR_WRITE;
				end else begin
					next_r.oe_n  = 1'b0; // RULE10 RULE12
					next_r.state = ASR_READ;
				end
			end
			ASR_READ: begin
				next_r.cnt = r.cnt + 4'h1;
				// Sampled data lags pins by the synchroniser depth.
				if (r.cnt == READ_CYC + 4'h1) begin // RULE11
					next_r.rdata     = data_sync;
					next_r.rsp_valid = 1'b1;
					next_r.sel_n     = 1'b1; // RULE14
					next_r.oe_n      = 1'b1;
					next_r.cnt       = '0;
					next_r.state     = ASR_TURN;
				end
			end
			ASR_WRITE: begin
				next_r.cnt = r.cnt + 4'h1;
				if (r.cnt == WRITE_CYC - 4'h1) begin // RULE16
					next_r.we_n  = 1'b1; // RULE7
					next_r.sel_n = 1'b1;
					next_r.state = ASR_HOLD;
				end
			end
			ASR_HOLD: begin
				// Data and address stay one cycle after the write end.
				next_r.drive_n = 1'b1; // RULE18 RULE19
				next_r.cnt     = '0;
				next_r.state   = ASR_TURN;
			end
			ASR_TURN: begin
				// Bus turnaround so the memory has floated.
				next_r.cnt = r.cnt + 4'h1;
				if (r.cnt == TURN_CYC - 4'h1) begin // RULE14 RULE10
					next_r.state = ASR_IDLE;
				end
			end
			default: begin
				next_r.state = ASR_IDLE;
			end
		endcase
	end

	// State register with synchronous reset to a deselected bus.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			r         <= '0;
			r.state   <= ASR_IDLE;
			r.lane_n  <= 2'b11;
			r.sel_n   <= 1'b1; // RULE3
			r.oe_n    <= 1'b1;
			r.we_n    <= 1'b1;
			r.drive_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign req_ready_out              = (r.state == ASR_IDLE);
	assign rsp_valid_out              = r.rsp_valid;
	assign rsp_rdata_out              = r.rdata;
	assign word_address_out           = r.addr;
	assign select_n_out               = r.sel_n;
	assign output_enable_n_out        = r.oe_n;
	assign write_strobe_n_out         = r.we_n;
	assign low_lane_select_n_out      = r.lane_n[0];
	assign high_lane_select_n_out     = r.lane_n[1];
	assign shared_data_lines_out      = r.wdata;
	assign shared_data_lines_oe_n_out = r.drive_n;
endmodule : asr_ctrl

/* dv/asr_mem_model.sv */
`timescale 1ns/1ps
// Static memory standing on the far side of the controller.
module asr_mem (
	input  wire logic [17:0] a_in,
	input  wire logic        s_n_in,
	input  wire logic        o_n_in,
	input  wire logic        w_n_in,
	input  wire logic        l_n_in,
	input  wire logic        u_n_in,
	input  wire logic [15:0] d_in,
	output logic      [15:0] q_out,
	output logic      [1:0]  e_out
);
	logic [15:0] m [0:262143];
	logic        wr;
	// Selected lanes are stored while the write overlap lasts.
	assign wr = !s_n_in && !w_n_in;
	always @* begin
		if (wr && !l_n_in) m[a_in][7:0] = d_in[7:0];
		if (wr && !u_n_in) m[a_in][15:8] = d_in[15:8];
	end
	// A lane drives only in a read with its own select low.
	assign #3 e_out = {2{!s_n_in && !o_n_in && w_n_in}}
		& ~{u_n_in, l_n_in};
	logic [17:0] a_hold;
	logic [17:0] a_acc;
	// Old data holds briefly, then is unknown until the access time is met.
	assign #3 a_hold = a_in;
	assign #12 a_acc = a_in;
	assign q_out = (a_hold == a_acc) ? m[a_acc] : 16'hxxxx;
endmodule : asr_mem

/* dv/asr_ctrl_asserts.sv */
`timescale 1ns/1ps
// Checks on the memory pins and the request handshake of the controller.
module asr_chk (
	input logic        mclk_in,
	input logic        rst_in,
	input logic        req_valid_in,
	input logic        req_ready_out,
	input logic        req_write_in,
	input logic        rsp_valid_out,
	input logic [17:0] word_address_out,
	input logic        select_n_out,
	input logic        output_enable_n_out,
	input logic        write_strobe_n_out,
	input logic [15:0] shared_data_lines_out,
	input logic        shared_data_lines_oe_n_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	AST_ADR: assert property (!write_strobe_n_out |->
		$stable(word_address_out)) else $error("addr moved");
	AST_END: assert property ($rose(write_strobe_n_out) |->
		$stable(word_address_out)) else $error("addr left early");
	AST_BUS: assert property (!select_n_out && !output_enable_n_out
		|-> shared_data_lines_oe_n_out) else $error("bus clash");
	AST_ANS: assert property (req_valid_in && req_ready_out &&
		!req_write_in |-> ##6 rsp_valid_out) else $error("no answer");
	AST_RDW: assert property ($fell(output_enable_n_out) |->
		!output_enable_n_out[*4]) else $error("read short");
	AST_WP: assert property ($rose(write_strobe_n_out) |->
		$past(select_n_out) == 1'b0) else $error("pulse short");
	AST_SU: assert property ($fell(write_strobe_n_out) |->
		!shared_data_lines_oe_n_out && $stable(shared_data_lines_out)
		&& $stable(word_address_out)) else $error("data setup");
	AST_DH: assert property ($rose(write_strobe_n_out) |->
		!shared_data_lines_oe_n_out && $stable(shared_data_lines_out))
		else $error("data hold");
	C_RD: cover property (rsp_valid_out);
	C_WR: cover property ($fell(write_strobe_n_out));
	C_RDY: cover property ($rose(req_ready_out));
endmodule : asr_chk
bind asr_ctrl asr_chk u_asr_chk (.*);

/* dv/tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD %0t got %h want %h", $time, g, e); end end
// Controller against the memory model.
module tb_top;
	logic        mclk_in = 0, rst_in = 1, v = 0, w = 0;
	logic        rdy, rsp, sn, on, wn, ln, un, bn;
	logic [17:0] adr = 0, ma;
	logic [15:0] wd = 0, rd, dq, q, bus, last = 0;
	logic [1:0]  le = 0, qe;
	int          n_errors = 0, tests_run = 0, cyc = 0;
	asr_ctrl u_asr_ctrl (.mclk_in(mclk_in), .rst_in(rst_in),
		.req_valid_in(v), .req_ready_out(rdy), .req_write_in(w),
		.req_addr_in(adr), .req_wdata_in(wd), .req_lane_en_in(le),
		.rsp_valid_out(rsp), .rsp_rdata_out(rd), .word_address_out(ma),
		.select_n_out(sn), .output_enable_n_out(on),
		.write_strobe_n_out(wn), .low_lane_select_n_out(ln),
		.high_lane_select_n_out(un), .shared_data_lines_in(bus),
		.shared_data_lines_out(dq), .shared_data_lines_oe_n_out(bn));
	asr_mem u_asr_mem (.a_in(ma), .s_n_in(sn), .o_n_in(on), .w_n_in(wn),
		.l_n_in(ln), .u_n_in(un), .d_in(dq), .q_out(q), .e_out(qe));
	// Clock, and idle lanes showing the inverse of their last level.
	always #12.5 mclk_in = ~mclk_in;
	assign bus = !bn ? dq : {qe[1] ? q[15:8] : ~last[15:8],
		qe[0] ? q[7:0] : ~last[7:0]};
	always @(posedge mclk_in) begin
		last <= bus;
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			close_out();
		end
	end
	task automatic close_out;
		$display("errors %0d compares %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	// One request, held until taken; a read waits for its answer.
	task automatic req(input logic wr, input logic [17:0] a,
		input logic [15:0] d, input logic [1:0] l);
		int k;
		k = 0;
		{v, w, adr, wd, le} = {1'b1, wr, a, d, l};
		while (rdy !== 1'b1 && k < 20) begin
			@(posedge mclk_in);
			#1 k++;
		end
		@(posedge mclk_in);
		#1 v = 0;
		`CHK(k < 20, 1'b1)
		while (!wr && rsp !== 1'b1 && k < 40) begin
			@(posedge mclk_in);
			#1 k++;
		end
		`CHK(k < 40, 1'b1)
		@(posedge mclk_in);
		#1;
		if (!wr) `CHK(rsp, 1'b0)
	endtask : req
	// Back-to-back full words at both ends of the address range.
	task automatic t_full;
		req(1, 18'h3ffff, 16'ha5c3, 2'b11);
		req(1, 18'h00000, 16'h5a3c, 2'b11);
		req(0, 18'h3ffff, 16'h0000, 2'b11);
		`CHK(rd, 16'ha5c3)
		req(0, 18'h00000, 16'h0000, 2'b11);
		`CHK(rd, 16'h5a3c)
	endtask : t_full
	// A high-lane write leaves the low lane untouched.
	task automatic t_lane;
		req(1, 18'h3ffff, 16'h1234, 2'b10);
		req(0, 18'h3ffff, 16'h0000, 2'b01);
		`CHK(rd[7:0], 8'hc3)
		req(0, 18'h3ffff, 16'h0000, 2'b10);
		`CHK(rd[15:8], 8'h12)
		req(1, 18'h3ffff, 16'hffff, 2'b00);
		req(0, 18'h3ffff, 16'h0000, 2'b11);
		`CHK(rd, 16'h12c3)
	endtask : t_lane
	// A reset in mid-read leaves the pins idle and the memory intact.
	task automatic t_reset;
		{v, w, adr, le} = {1'b1, 1'b0, 18'h00000, 2'b11};
		@(posedge mclk_in);
		#1 v = 0;
		repeat (2) @(posedge mclk_in);
		#1 rst_in = 1;
		repeat (2) @(posedge mclk_in);
		#1 rst_in = 0;
		`CHK({rdy, rsp, sn, on, wn, ln, un, bn}, 8'hbf)
		req(0, 18'h00000, 16'h0000, 2'b11);
		`CHK(rd, 16'h5a3c)
	endtask : t_reset
	initial begin
		repeat (6) @(posedge mclk_in);
		#1 rst_in = 0;
		t_full();
		t_lane();
		t_reset();
		close_out();
	end
endmodule : tb_top
